/* core/bsr_pkg.sv */
package bsr_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_DIM_LEVEL      = 8'h00;
  localparam logic [7:0] IDX_DEVICE_CONTROL = 8'h01;
  localparam logic [7:0] IDX_FAULT_STATUS   = 8'h02;
  localparam logic [7:0] IDX_IDENTIFICATION = 8'h03;

  localparam logic [7:0] DIM_LEVEL_RESET    = 8'hFF;
  localparam logic [5:0] CONTROL_RESET      = 6'h00;
  localparam logic [7:0] BYTE_ZERO          = 8'h00;
  localparam logic [7:0] BYTE_FULL          = 8'hFF;

  // control fields
  localparam int CTL_ON_BIT     = 0;
  localparam int CTL_SEL_BIT    = 1;
  localparam int CTL_MD_BIT     = 2;
  localparam int CTL_STORE_MSB  = 5;

  // status fields
  localparam int ST_FAULT_BIT   = 0;

  // identification defaults; vendor and revision values are arbitrary
  localparam logic       ID_PANEL_DEFAULT  = 1'b1;
  localparam logic [3:0] ID_VENDOR_DEFAULT = 4'h3;
  localparam logic [2:0] ID_REV_DEFAULT    = 3'h0;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ          = 100;
  localparam int LIT_MAX_US       = 4000;
  localparam int LIT_DELAY_US     = 2000;
  localparam int LIT_DELAY_CYC    = LIT_DELAY_US * CLK_MHZ;
  localparam int DUTY_WIN_LOG2    = 16;
  localparam logic [7:0] PWM_LAST = 8'hFE;

  typedef enum logic [1:0] {
    BSR_OFF      = 2'b00,
    BSR_STARTING = 2'b01,
    BSR_LIT      = 2'b11
  } bsr_lamp_t;

endpackage : bsr_pkg

/* core/bsr_register_bank.sv */
module bsr_register_bank
  import bsr_pkg::*;
#(
  parameter int LIT_DELAY = LIT_DELAY_CYC,
  parameter int WIN_LOG2  = DUTY_WIN_LOG2
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // link side, byte transactions from bus framing
  input  wire logic       linkClk,
  input  wire logic       linkWrReq,
  input  wire logic       linkRdReq,
  input  wire logic [7:0] linkIndex,
  input  wire logic [7:0] linkWrData,
  output logic      [7:0] linkRdData,
  output logic            linkRdValid,
  output logic            linkBusy,
  // analog side inputs
  input  wire logic       extDimIn,
  input  wire logic       multiChanOffIn,
  input  wire logic       singleChanOffIn,
  input  wire logic       overcurrentIn,
  input  wire logic       thermalIn,
  // lamp outputs
  output logic            ledPwm,
  output logic            backlightLit,
  output logic      [7:0] activeLevel
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] scale_level(input logic [7:0] a, input logic [7:0] b);
    logic [15:0] prod;
    // widen first: a bare product inside a concatenation keeps only 8 bits
    prod = ({8'h00, a} * {8'h00, b}) + {8'h00, BYTE_FULL};
    return prod[15:8];
  endfunction : scale_level

  function automatic logic sync_edge(input logic cur, input logic prev);
    return cur ^ prev;
  endfunction : sync_edge

  // ---------------------------------------------------------------
  // link domain: request capture
  // ---------------------------------------------------------------
  logic       reqTgl;
  logic       reqIsRead;
  logic [7:0] reqIndex;
  logic [7:0] reqData;
  logic       ackS1;
  logic       ackS2;
  logic       ackSeen;
  logic       ackTgl;
  logic [7:0] rdHold;

  wire linkIdle  = (reqTgl == ackSeen) && (ackS2 == ackSeen);
  wire linkStart = linkIdle && (linkWrReq || linkRdReq);
  wire ackArrive = sync_edge(ackS2, ackSeen);

  assign linkBusy = !linkIdle;

  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      reqTgl <= 1'b0;
    end else if (linkStart) begin
      reqTgl <= ~reqTgl;
    end
  end

  // index and data stay frozen while busy; core reads them only then
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      reqIsRead <= 1'b0;
      reqIndex  <= BYTE_ZERO;
      reqData   <= BYTE_ZERO;
    end else if (linkStart) begin
      reqIsRead <= linkRdReq;
      reqIndex  <= linkIndex;
      reqData   <= linkWrData;
    end
  end

  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      ackS1 <= 1'b0;
      ackS2 <= 1'b0;
    end else begin
      ackS1 <= ackTgl;
      ackS2 <= ackS1;
    end
  end

  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      ackSeen <= 1'b0;
    end else begin
      ackSeen <= ackS2;
    end
  end

  // rdHold loads on the same edge as the ack toggle and is stable until the next request
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      linkRdData  <= BYTE_ZERO;
      linkRdValid <= 1'b0;
    end else begin
      linkRdValid <= ackArrive && reqIsRead;
      if (ackArrive && reqIsRead) begin
        linkRdData <= rdHold;
      end
    end
  end

  // ---------------------------------------------------------------
  // core domain: synchronisers
  // ---------------------------------------------------------------
  logic reqS1, reqS2, reqS3;
  logic [4:0] pinS1;
  logic [4:0] pinS2;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reqS1 <= 1'b0;
      reqS2 <= 1'b0;
      reqS3 <= 1'b0;
    end else begin
      reqS1 <= reqTgl;
      reqS2 <= reqS1;
      reqS3 <= reqS2;
    end
  end

  // pins are levels, so each bit may resolve a cycle apart; none is a word
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pinS1 <= 5'h00;
      pinS2 <= 5'h00;
    end else begin
      pinS1 <= {extDimIn, multiChanOffIn, singleChanOffIn, overcurrentIn, thermalIn};
      pinS2 <= pinS1;
    end
  end

  wire extDim        = pinS2[4];
  wire multiChanOff  = pinS2[3];
  wire singleChanOff = pinS2[2];
  wire overcurrent   = pinS2[1];
  wire thermalTrip   = pinS2[0];

  // ---------------------------------------------------------------
  // core domain: register decode
  // ---------------------------------------------------------------
  logic [7:0] dimLevel;
  logic [5:0] control;
  logic       faultSticky;
  bsr_lamp_t  lamp;

  wire reqEvt   = sync_edge(reqS2, reqS3);
  wire wrEvt    = reqEvt && !reqIsRead;
  wire wrLevel  = wrEvt && (reqIndex == IDX_DIM_LEVEL);
  wire wrCtl    = wrEvt && (reqIndex == IDX_DEVICE_CONTROL);
  wire wrStatus = wrEvt && (reqIndex == IDX_FAULT_STATUS);

  wire onCmd    = control[CTL_ON_BIT];
  wire srcExt   = control[CTL_SEL_BIT];
  wire interpAbs = control[CTL_MD_BIT];

  wire hostMode = !srcExt;
  wire onToggle = wrCtl && (reqData[CTL_ON_BIT] != onCmd);
  wire faultClr = onToggle || (wrStatus && !reqData[ST_FAULT_BIT]);
  wire anyFault = multiChanOff || singleChanOff || overcurrent || thermalTrip;

  wire [7:0] statusByte = {2'b00, multiChanOff, singleChanOff, backlightLit,
                           overcurrent, thermalTrip, faultSticky};
  wire [7:0] idByte     = {ID_PANEL_DEFAULT, ID_VENDOR_DEFAULT, ID_REV_DEFAULT};
  wire [7:0] ctlByte    = {2'b00, control};

  logic [7:0] rdMux;
  always_comb begin
    unique case (reqIndex)
      IDX_DIM_LEVEL:      rdMux = dimLevel;
      IDX_DEVICE_CONTROL: rdMux = ctlByte;
      IDX_FAULT_STATUS:   rdMux = statusByte;
      IDX_IDENTIFICATION: rdMux = idByte;
      default:            rdMux = BYTE_ZERO;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ackTgl <= 1'b0;
    end else if (reqEvt) begin
      ackTgl <= ~ackTgl;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdHold <= BYTE_ZERO;
    end else if (reqEvt) begin
      rdHold <= rdMux;
    end
  end

  // ---------------------------------------------------------------
  // core domain: writable registers
  // ---------------------------------------------------------------
  // writes to status bits 7:1 and identification land nowhere
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dimLevel <= DIM_LEVEL_RESET;
    end else if (wrLevel && hostMode) begin
      dimLevel <= reqData;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      control <= CONTROL_RESET;
    end else if (wrCtl) begin
      control <= reqData[CTL_STORE_MSB:0];
    end
  end

  // set wins over clear: a persisting fault re-asserts at once
  wire next_faultSticky = anyFault || (faultSticky && !faultClr);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      faultSticky <= 1'b0;
    end else begin
      faultSticky <= next_faultSticky;
    end
  end

  // ---------------------------------------------------------------
  // external dimming duty measurement
  // ---------------------------------------------------------------
  logic [WIN_LOG2-1:0] winCnt;
  logic [WIN_LOG2:0]   highCnt;
  logic [7:0]          extDuty;

  // fixed window average; input periods longer than the window beat
  wire       winEnd    = &winCnt;
  wire [WIN_LOG2:0] highNext = highCnt + {{WIN_LOG2{1'b0}}, extDim};
  wire [8:0] dutyShift = highNext[WIN_LOG2 -: 9];
  wire [7:0] dutySample = dutyShift[8] ? BYTE_FULL : dutyShift[7:0];

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      winCnt <= '0;
    end else begin
      winCnt <= winCnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      highCnt <= '0;
      extDuty <= BYTE_ZERO;
    end else if (winEnd) begin
      highCnt <= '0;
      extDuty <= dutySample;
    end else begin
      highCnt <= highNext;
    end
  end

  // ---------------------------------------------------------------
  // brightness source selection
  // ---------------------------------------------------------------
  wire [7:0] scaledLevel = scale_level(dimLevel, extDuty);
  wire [7:0] next_activeLevel = srcExt    ? extDuty :
                                interpAbs ? dimLevel :
                                            scaledLevel;

  // ---------------------------------------------------------------
  // lamp sequencing
  // ---------------------------------------------------------------
  logic [31:0] litCnt;
  bsr_lamp_t   next_lamp;

  wire litDone = (litCnt >= 32'(LIT_DELAY - 1));

  always_comb begin
    next_lamp = lamp;
    unique case (lamp)
      BSR_OFF:      if (onCmd) next_lamp = BSR_STARTING;
      BSR_STARTING: if (!onCmd) next_lamp = BSR_OFF;
                    else if (litDone) next_lamp = BSR_LIT;
      BSR_LIT:      if (!onCmd) next_lamp = BSR_OFF;
      default:      next_lamp = BSR_OFF;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lamp <= BSR_OFF;
    end else begin
      lamp <= next_lamp;
    end
  end

  // counts only while starting, so a quick off and on restarts the delay
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      litCnt <= '0;
    end else begin
      litCnt <= (lamp == BSR_STARTING) ? litCnt + 32'h1 : 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // output duty generator
  // ---------------------------------------------------------------
  // period of 255 steps so that 0xFF is continuous and 0x01 is 1/255
  logic [7:0] pwmCnt;
  wire  [7:0] next_pwmCnt = (pwmCnt == PWM_LAST) ? BYTE_ZERO : pwmCnt + 8'h01;
  wire        pwmHigh     = (pwmCnt < activeLevel);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pwmCnt <= BYTE_ZERO;
    end else begin
      pwmCnt <= next_pwmCnt;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      activeLevel <= BYTE_ZERO;
    end else begin
      activeLevel <= next_activeLevel;
    end
  end

  // both follow next_lamp so that status and light switch in one cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ledPwm       <= 1'b0;
      backlightLit <= 1'b0;
    end else begin
      backlightLit <= (next_lamp == BSR_LIT);
      ledPwm       <= (next_lamp == BSR_LIT) && pwmHigh;
    end
  end

endmodule : bsr_register_bank

/* tb/bsr_register_bank_asserts.sv */
module bsr_register_bank_asserts (
  // clocks
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic       linkClk,
  // watched
  input wire logic       linkWrReq,
  input wire logic       linkRdReq,
  input wire logic [7:0] linkRdData,
  input wire logic       linkRdValid,
  input wire logic       linkBusy,
  input wire logic       ledPwm,
  input wire logic       backlightLit,
  input wire logic [7:0] activeLevel
);
  timeunit 1ns;
  timeprecision 100ps;
  AST_TAKE: assert property (@(posedge linkClk) disable iff (!rst_b)
    (linkWrReq || linkRdReq) && !linkBusy |=> linkBusy) else $error("not taken");
  AST_RD_ANS: assert property (@(posedge linkClk) disable iff (!rst_b)
    linkRdReq && !linkBusy |-> ##[3:7] linkRdValid) else $error("no answer");
  AST_BUSY_END: assert property (@(posedge linkClk) disable iff (!rst_b)
    $rose(linkBusy) |-> ##[1:8] !linkBusy) else $error("busy stuck");
  AST_RDV_ONE: assert property (@(posedge linkClk) disable iff (!rst_b)
    linkRdValid |-> !linkBusy ##1 !linkRdValid) else $error("bad valid");
  AST_RD_HOLD: assert property (@(posedge linkClk) disable iff (!rst_b)
    !linkRdValid |-> $stable(linkRdData)) else $error("data moved");
  AST_DARK: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !backlightLit [*2] |-> !ledPwm) else $error("pwm while dark");
  AST_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (activeLevel == 8'h00) [*2] |-> !ledPwm) else $error("pwm at zero");
  AST_FULL: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (backlightLit && activeLevel == 8'hFF) [*2] |-> ledPwm) else $error("gap at full");
  C_RD: cover property (@(posedge linkClk) disable iff (!rst_b) linkRdValid);
  C_LIT: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(backlightLit));
  C_PWM: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(ledPwm));
endmodule : bsr_register_bank_asserts

bind bsr_register_bank bsr_register_bank_asserts u_chk (.*);

/* tb/bsr_host_model.sv */
module bsr_host_model (
  // requests
  output logic       linkClk,
  output logic       linkWrReq,
  output logic       linkRdReq,
  output logic [7:0] linkIndex,
  output logic [7:0] linkWrData,
  // answer
  input  wire logic  linkBusy
);
  timeunit 1ns;
  timeprecision 100ps;
  logic run;

  // clock parks low between frames
  initial begin
    {linkClk, run, linkWrReq, linkRdReq} = 4'h0;
    {linkIndex, linkWrData} = 16'hA55A;
    #3;
    forever begin
      #80;
      if (run || linkClk) linkClk = ~linkClk;
    end
  end

  // gap gives a slow start
  task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d, input int gap);
    int n;
    run = 1'b1;
    repeat (gap + 1) @(posedge linkClk);
    linkWrReq  <= w;
    linkRdReq  <= !w;
    linkIndex  <= i;
    linkWrData <= d;
    @(posedge linkClk);
    linkWrReq  <= 1'b0;
    linkRdReq  <= 1'b0;
    // released lines never keep the last value
    linkIndex  <= ~i;
    linkWrData <= ~d;
    n = 0;
    do begin
      @(negedge linkClk);
      n++;
    end while (linkBusy !== 1'b0 && n < 16);
    @(negedge linkClk);
    run = 1'b0;
  endtask : xfer
endmodule : bsr_host_model

/* tb/bsr_register_bank_tb.sv */
module bsr_register_bank_tb;
  import bsr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LIT = 20;
  localparam logic [7:0] ID = {ID_PANEL_DEFAULT, ID_VENDOR_DEFAULT, ID_REV_DEFAULT};
  logic       ref_clk, rst_b, extDimIn, linkClk, linkWrReq, linkRdReq, linkRdValid;
  logic       multiChanOffIn, singleChanOffIn, overcurrentIn, thermalIn;
  logic       linkBusy, ledPwm, backlightLit;
  logic [7:0] linkIndex, linkWrData, linkRdData, activeLevel, lvl;
  logic [7:0] expQ[$];
  logic [3:0] flt;
  int         fails, cmp_count, seed, cyc;

  bsr_register_bank #(.LIT_DELAY(LIT), .WIN_LOG2(8)) uut (.*);
  bsr_host_model host (.*);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // each answer takes the oldest note
  always @(posedge linkClk) begin
    if (linkRdValid === 1'b1) chk("rd", linkRdData, expQ.size() ? expQ.pop_front() : ~linkRdData);
  end

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    host.xfer(1'b1, i, d, {$random(seed)} % 3);
  endtask : wr

  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    expQ.push_back(e);
    host.xfer(1'b0, i, 8'h00, {$random(seed)} % 3);
  endtask : rd

  task automatic ext(input logic v, input logic [7:0] e);
    @(posedge ref_clk);
    extDimIn <= v;
    repeat (800) @(posedge ref_clk);
    chk("lvl", activeLevel, e);
  endtask : ext

  task automatic pwm(input logic [7:0] e);
    int n;
    n = 0;
    chk("lvl", activeLevel, e);
    repeat (255) begin
      @(posedge ref_clk);
      n += ledPwm;
    end
    chk("pwm", 8'(n), e);
  endtask : pwm

  task automatic setf(input logic [3:0] f);
    @(posedge ref_clk);
    {multiChanOffIn, singleChanOffIn, overcurrentIn, thermalIn} <= f;
    repeat (5) @(posedge ref_clk);
  endtask : setf

  task automatic results();
    if (expQ.size() != 0) fails++;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  initial begin
    seed = 35;
    rst_b = 1'b0;
    extDimIn = 1'b0;
    {multiChanOffIn, singleChanOffIn, overcurrentIn, thermalIn} = 4'h0;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(IDX_DIM_LEVEL, 8'hFF);
    rd(IDX_DEVICE_CONTROL, 8'h00);
    rd(IDX_FAULT_STATUS, 8'h00);
    rd(IDX_IDENTIFICATION, ID);
    rd(8'h04, 8'h00);
    $display("test reset done");
    wr(IDX_DEVICE_CONTROL, 8'hFA);
    rd(IDX_DEVICE_CONTROL, 8'h3A);
    wr(IDX_DIM_LEVEL, 8'h12);
    rd(IDX_DIM_LEVEL, 8'hFF);
    wr(IDX_IDENTIFICATION, 8'h00);
    rd(IDX_IDENTIFICATION, ID);
    wr(IDX_FAULT_STATUS, 8'hFE);
    rd(IDX_FAULT_STATUS, 8'h00);
    $display("test access done");
    ext(1'b1, 8'hFF);
    ext(1'b0, 8'h00);
    $display("test source done");
    wr(IDX_DEVICE_CONTROL, 8'h05);
    repeat (LIT + 5) @(posedge ref_clk);
    chk("lit", {7'h00, backlightLit}, 8'h01);
    rd(IDX_FAULT_STATUS, 8'h08);
    for (int k = 0; k < 3; k++) begin
      lvl = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($random(seed));
      wr(IDX_DIM_LEVEL, lvl);
      rd(IDX_DIM_LEVEL, lvl);
      pwm(lvl);
    end
    wr(IDX_DEVICE_CONTROL, 8'h01);
    ext(1'b1, lvl);
    lvl = 8'($random(seed));
    wr(IDX_DIM_LEVEL, lvl);
    ext(1'b1, lvl);
    ext(1'b0, 8'h00);
    $display("test level done");
    for (int k = 0; k < 4; k++) begin
      flt = 4'h1 << k;
      setf(flt);
      rd(IDX_FAULT_STATUS, {2'b00, flt[3:2], 1'b1, flt[1:0], 1'b1});
      setf(4'h0);
      rd(IDX_FAULT_STATUS, 8'h09);
      wr(IDX_FAULT_STATUS, 8'h00);
      rd(IDX_FAULT_STATUS, 8'h08);
    end
    setf(4'h1);
    setf(4'h0);
    wr(IDX_DEVICE_CONTROL, 8'h04);
    rd(IDX_FAULT_STATUS, 8'h00);
    chk("lit", {7'h00, backlightLit}, 8'h00);
    $display("test faults done");
    results();
  end
endmodule : bsr_register_bank_tb
